/* adcs_pkg.sv */
// Purpose: shared constants for the conversion and read sequencer
// Assumes: 100 MHz system clock, all pins synchronous to it
// Notes:   conversion times are typical figures in microseconds
`default_nettype none
package adcs_pkg;
    localparam int unsigned CLK_FREQ_MHZ  = 100;          // cycles per microsecond
    localparam int unsigned NUM_CHANNELS  = 4;
    localparam int unsigned WORD_W        = 16;
    localparam int unsigned PTR_W         = 2;
    localparam int unsigned RATIO_W       = 3;
    localparam int unsigned COUNT_W       = 16;
    // busy time per oversampling code, microseconds; code 7 is reserved
    localparam int unsigned CONV_TIME_US [8] = '{2, 5, 11, 23, 47, 95, 191, 2};
    localparam logic [RATIO_W-1:0] RATIO_RESET = 3'h0;
    localparam logic [PTR_W-1:0]   PTR_FIRST   = 2'h0;
    localparam logic [WORD_W-1:0]  WORD_RESET  = 16'h0000;
endpackage
`default_nettype wire

/* adcs_res_if.sv */
// Purpose: carrier between the sequencer and its result store
// Assumes: single clock domain
// Notes:   all four channels are written in one cycle
`default_nettype none
interface adcs_res_if;
    logic                                                     wr_en;
    logic [adcs_pkg::NUM_CHANNELS*adcs_pkg::WORD_W-1:0]       wr_data;
    logic [adcs_pkg::PTR_W-1:0]                               rd_addr;
    logic [adcs_pkg::WORD_W-1:0]                              rd_data;
    modport seq (output wr_en, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

/* adcs_result_mem.sv */
// Purpose: holds the four channel results of the last conversion
// Assumes: read address is sampled every cycle
// Notes:   read data come from a register, one cycle after the address
`default_nettype none
module adcs_result_mem (
    input  wire logic clock,
    input  wire logic rst_n,
    adcs_res_if.mem   res
);
    logic [adcs_pkg::WORD_W-1:0] word [adcs_pkg::NUM_CHANNELS];

    // parallel write of every channel at the end of a conversion
    for (genvar i = 0; i < adcs_pkg::NUM_CHANNELS; i++) begin : g_word
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                word[i] <= adcs_pkg::WORD_RESET;
            end else if (res.wr_en) begin
                word[i] <= res.wr_data[i*adcs_pkg::WORD_W +: adcs_pkg::WORD_W];
            end
        end
    end

    // registered read port; written data pass through so the next cycle never reads stale
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            res.rd_data <= adcs_pkg::WORD_RESET;
        end else if (res.wr_en) begin
            res.rd_data <= res.wr_data[res.rd_addr*adcs_pkg::WORD_W +: adcs_pkg::WORD_W];
        end else begin
            res.rd_data <= word[res.rd_addr];
        end
    end
endmodule
`default_nettype wire

/* adcs_top.sv */
// Purpose: conversion start, busy timing and parallel read-out sequencing
// Assumes: host honours its own wake-up, spacing and setup figures
// Notes:   two-way pins appear as output value plus output enable
`default_nettype none
// How it works
// - Busy stays high for the conversion time of the latched oversampling ratio.
// - The later of the two convert-start rises starts conversion and raises busy.
// - Chip select low drives the data bus and each read fall presents the next word.
// - With separate strobes the flag goes low on select, tracks reads, floats on deselect.
// - With tied strobes each fall drives flag and word and each rise floats both.
module adcs_top #(
    parameter int unsigned CYCLES_PER_US = adcs_pkg::CLK_FREQ_MHZ
) (
    input  wire logic                                               clock,
    input  wire logic                                               rst_n,
    input  wire logic                                               convert_start_a,
    input  wire logic                                               convert_start_b,
    input  wire logic [adcs_pkg::RATIO_W-1:0]                       oversample_select,
    input  wire logic                                               low_power_request_n,
    input  wire logic                                               device_reset,
    input  wire logic                                               chip_select_n,
    input  wire logic                                               read_n,
    input  wire logic                                               strobes_tied,
    input  wire logic [adcs_pkg::NUM_CHANNELS*adcs_pkg::WORD_W-1:0] channel_sample,
    output logic                                                    busy,
    output logic [adcs_pkg::WORD_W-1:0]                             parallel_data_bus,
    output logic                                                    parallel_data_bus_oe,
    output logic                                                    first_channel_flag,
    output logic                                                    first_channel_flag_oe
);
    adcs_res_if res ();

    logic                                                   prev_a;
    logic                                                   prev_b;
    logic                                                   prev_cs_n;
    logic                                                   prev_rd_n;
    logic                                                   seen_a;
    logic                                                   seen_b;
    logic                                                   start;
    logic                                                   rise_a;
    logic                                                   rise_b;
    logic                                                   cs_fall;
    logic                                                   cs_rise;
    logic                                                   rd_fall;
    logic                                                   word_strobe;
    logic                                                   conv_done;
    logic [adcs_pkg::RATIO_W-1:0]                           ratio;
    logic [adcs_pkg::COUNT_W-1:0]                           busy_cnt;
    logic [adcs_pkg::COUNT_W-1:0]                           conv_cycles;
    logic [adcs_pkg::PTR_W-1:0]                             ptr;
    logic [adcs_pkg::NUM_CHANNELS*adcs_pkg::WORD_W-1:0]     held;

    adcs_result_mem u_mem (
        .clock (clock),
        .rst_n (rst_n),
        .res   (res.mem)
    );

    // edge detection on synchronous pins
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev_a    <= 1'b0;
            prev_b    <= 1'b0;
            prev_cs_n <= 1'b1;
            prev_rd_n <= 1'b1;
        end else begin
            prev_a    <= convert_start_a;
            prev_b    <= convert_start_b;
            prev_cs_n <= chip_select_n;
            prev_rd_n <= read_n;
        end
    end

    assign rise_a  = convert_start_a && !prev_a;
    assign rise_b  = convert_start_b && !prev_b;
    assign cs_fall = !chip_select_n && prev_cs_n;
    assign cs_rise = chip_select_n && !prev_cs_n;
    assign rd_fall = !read_n && prev_rd_n && !chip_select_n;
    // tied strobes: the joint falling edge is the read
    assign word_strobe = strobes_tied ? cs_fall : rd_fall;

    // start on the trailing rise; standby and reset hold off starts
    assign start = !busy && !device_reset && low_power_request_n
                 && (seen_a || rise_a) && (seen_b || rise_b);

    // remember which start input has risen in this conversion
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            seen_a <= 1'b0;
            seen_b <= 1'b0;
        end else if (device_reset || !low_power_request_n || start || busy) begin
            seen_a <= 1'b0; // edges in standby or during busy are not a new request
            seen_b <= 1'b0;
        end else begin
            seen_a <= seen_a || rise_a;
            seen_b <= seen_b || rise_b;
        end
    end

    assign conv_cycles = adcs_pkg::COUNT_W'(adcs_pkg::CONV_TIME_US[ratio] * CYCLES_PER_US);
    assign conv_done   = busy && (busy_cnt == '0);

    // busy timer; reset pin aborts a conversion in flight
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy     <= 1'b0;
            busy_cnt <= '0;
        end else if (device_reset) begin
            busy     <= 1'b0;
            busy_cnt <= '0;
        end else if (start) begin
            busy     <= 1'b1;
            busy_cnt <= conv_cycles - 1'b1;
        end else if (conv_done) begin
            busy     <= 1'b0;
        end else if (busy) begin
            busy_cnt <= busy_cnt - 1'b1;
        end
    end

    // ratio latched as busy falls, steering the following conversion
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ratio <= adcs_pkg::RATIO_RESET;
        end else if (device_reset) begin
            ratio <= adcs_pkg::RATIO_RESET;
        end else if (conv_done) begin
            ratio <= oversample_select;
        end
    end

    // inputs are held at the sampling instant, all channels together
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            held <= '0;
        end else if (start) begin
            held <= channel_sample;
        end
    end

    assign res.wr_en   = conv_done;
    assign res.wr_data = held;
    assign res.rd_addr = conv_done ? adcs_pkg::PTR_FIRST : ptr; // fresh set opens at channel 0

    // word pointer restarts with each fresh result set
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ptr <= adcs_pkg::PTR_FIRST;
        end else if (device_reset || conv_done) begin
            ptr <= adcs_pkg::PTR_FIRST;
        end else if (word_strobe) begin
            ptr <= ptr + 1'b1;
        end
    end

    // word under the pointer is taken at the strobe, before the pointer moves on,
    // so the first read after a conversion shows channel 0 beside the flag
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            parallel_data_bus <= adcs_pkg::WORD_RESET;
        end else if (word_strobe) begin
            parallel_data_bus <= res.rd_data;
        end
    end

    // bus and flag drive follow chip select in both strobe styles
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            parallel_data_bus_oe  <= 1'b0;
            first_channel_flag_oe <= 1'b0;
        end else begin
            parallel_data_bus_oe  <= !chip_select_n;
            first_channel_flag_oe <= !chip_select_n;
        end
    end

    // flag marks the first channel word on the bus
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            first_channel_flag <= 1'b0;
        end else if (word_strobe) begin
            first_channel_flag <= (ptr == adcs_pkg::PTR_FIRST);
        end else if (cs_fall) begin
            first_channel_flag <= 1'b0;
        end
    end

    // helper: length of the busy pulse in cycles
    logic [adcs_pkg::COUNT_W-1:0] busy_len;
    logic [adcs_pkg::COUNT_W-1:0] len_expect;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy_len   <= '0;
            len_expect <= '0;
        end else if (start) begin
            busy_len   <= '0;
            len_expect <= conv_cycles;
        end else if (busy) begin
            busy_len   <= busy_len + 1'b1;
        end
    end

    sequence s_start_seen;
        start ##1 busy;
    endsequence

    a_busy_on_trailing: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(busy) |-> $past(start))
        else $error("busy rose without a trailing start edge");
    a_start_on_edge: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(busy) |-> $past(rise_a || rise_b))
        else $error("busy rose with no start edge in the start cycle");
    a_start_raises_busy: assert property (@(posedge clock) disable iff (!rst_n)
        start && !device_reset |-> s_start_seen)
        else $error("busy not raised one cycle after start");
    a_busy_length: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(busy) && !$past(device_reset) |-> busy_len == len_expect)
        else $error("busy high time differs from the ratio figure");
    a_ratio_latch: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(busy) && !$past(device_reset) |-> ratio == $past(oversample_select))
        else $error("ratio not taken at busy falling");
    a_bus_drive: assert property (@(posedge clock) disable iff (!rst_n)
        cs_fall |=> parallel_data_bus_oe)
        else $error("data bus not driven after select");
    a_ptr_advance: assert property (@(posedge clock) disable iff (!rst_n)
        word_strobe && !conv_done && !device_reset |=> ptr == $past(ptr) + 1'b1)
        else $error("read did not advance the word");
    a_flag_sep_low: assert property (@(posedge clock) disable iff (!rst_n)
        cs_fall && !strobes_tied |=> first_channel_flag_oe && !first_channel_flag)
        else $error("flag not driven low on select");
    a_flag_first: assert property (@(posedge clock) disable iff (!rst_n)
        word_strobe && ptr == adcs_pkg::PTR_FIRST |=> first_channel_flag)
        else $error("flag not high for first channel");
    a_tied_release: assert property (@(posedge clock) disable iff (!rst_n)
        cs_rise |=> !parallel_data_bus_oe && !first_channel_flag_oe)
        else $error("bus or flag still driven after rise");
endmodule
`default_nettype wire

/* adcs_host_model.sv */
// Purpose: host controller model driving start, select and read strobes
// Assumes: every pin moves at the falling clock edge only
// Notes:   microsecond waits are scaled by CYCLES_PER_US; strobe, gap and reset-pulse widths are fixed cycle counts
`default_nettype none
module adcs_host_model #(
    parameter int unsigned CYCLES_PER_US = 1
) (
    input  wire logic                         clock,
    output var  logic                         convert_start_a,
    output var  logic                         convert_start_b,
    output var  logic [adcs_pkg::RATIO_W-1:0] oversample_select,
    output var  logic                         low_power_request_n,
    output var  logic                         device_reset,
    output var  logic                         chip_select_n,
    output var  logic                         read_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle host: in standby, deselected, no start pending
    initial begin
        convert_start_a     = 1'b0;
        convert_start_b     = 1'b0;
        oversample_select   = 3'h0;
        low_power_request_n = 1'b0;
        device_reset        = 1'b0;
        chip_select_n       = 1'b1;
        read_n              = 1'b1;
    end
    // a leads, b trails by gap cycles, far inside the skew limit
    task automatic convert(input int gap);
        convert_start_a = 1'b1;
        repeat (gap) @(negedge clock);
        convert_start_b = 1'b1;
        @(negedge clock);
        convert_start_a = 1'b0;
        convert_start_b = 1'b0;
    endtask
    // direct levels on both start inputs, for lead-only and trailing-edge cases
    task automatic drive_start(input logic a, input logic b);
        convert_start_a = a;
        convert_start_b = b;
    endtask
    // acquisition gap also keeps the cycle period above its minimum
    task automatic acquire();
        repeat (CYCLES_PER_US) @(negedge clock);
    endtask
    // only called between conversions, so pins are steady at busy fall
    task automatic set_ratio(input logic [adcs_pkg::RATIO_W-1:0] code);
        oversample_select = code;
    endtask
    task automatic sleep();
        low_power_request_n = 1'b0;
        @(negedge clock);
    endtask
    task automatic wake();
        low_power_request_n = 1'b1;
        repeat (100 * CYCLES_PER_US) @(negedge clock);
    endtask
    // reset pulse of 50 ns, then the start spacing; trusts results again
    task automatic reset_pulse();
        device_reset = 1'b1;
        repeat (5) @(negedge clock);
        device_reset = 1'b0;
        repeat (25 * CYCLES_PER_US) @(negedge clock);
    endtask
    // external reference wake-up figure; reference itself assumed ready
    task automatic exit_shutdown();
        low_power_request_n = 1'b1;
        repeat (13000 * CYCLES_PER_US) @(negedge clock);
        reset_pulse();
    endtask
    task automatic set_cs(input logic v);
        chip_select_n = v;
        repeat (2) @(negedge clock);
    endtask
    task automatic read_pulse();
        read_n = 1'b0;
        repeat (2) @(negedge clock);
        read_n = 1'b1;
        @(negedge clock);
    endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Purpose: self-checking bench for the conversion and read sequencer
// Assumes: one device cycle per microsecond keeps busy times short
// Notes:   inputs move at the falling edge, outputs are sampled there
`default_nettype none
`define CHK(name, exp, got) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
    $display("[FAIL] %s expected %h seen %h", name, exp, got); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [2:0] code; int cycles;} adcs_row_t;
    logic        clock = 1'b0;
    logic        rst_n, strobes_tied, busy, parallel_data_bus_oe;
    logic        first_channel_flag, first_channel_flag_oe;
    logic        convert_start_a, convert_start_b, low_power_request_n;
    logic        device_reset, chip_select_n, read_n;
    logic [2:0]  oversample_select;
    logic [15:0] parallel_data_bus;
    logic [63:0] channel_sample;
    int          failures = 0;
    int          cmp_count = 0;
    int          n;
    // ratio code beside the busy length it gives, code 7 acting as ratio 1
    adcs_row_t   rows [8] = '{'{3'h0, 2}, '{3'h1, 5}, '{3'h2, 11}, '{3'h3, 23},
                              '{3'h4, 47}, '{3'h5, 95}, '{3'h6, 191}, '{3'h7, 2}};
    always #5 clock = ~clock;
    adcs_top #(.CYCLES_PER_US(1)) i_dut (
        .clock                 (clock),
        .rst_n                 (rst_n),
        .convert_start_a       (convert_start_a),
        .convert_start_b       (convert_start_b),
        .oversample_select     (oversample_select),
        .low_power_request_n   (low_power_request_n),
        .device_reset          (device_reset),
        .chip_select_n         (chip_select_n),
        .read_n                (read_n),
        .strobes_tied          (strobes_tied),
        .channel_sample        (channel_sample),
        .busy                  (busy),
        .parallel_data_bus     (parallel_data_bus),
        .parallel_data_bus_oe  (parallel_data_bus_oe),
        .first_channel_flag    (first_channel_flag),
        .first_channel_flag_oe (first_channel_flag_oe)
    );
    adcs_host_model #(.CYCLES_PER_US(1)) i_host (
        .clock               (clock),
        .convert_start_a     (convert_start_a),
        .convert_start_b     (convert_start_b),
        .oversample_select   (oversample_select),
        .low_power_request_n (low_power_request_n),
        .device_reset        (device_reset),
        .chip_select_n       (chip_select_n),
        .read_n              (read_n)
    );
    task automatic final_report();
        if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // busy length counted at falling edges; bounded so a stuck busy ends
    task automatic run_conv(input int gap, output int len);
        len = 0;
        i_host.convert(gap);
        repeat (3) if (busy !== 1'b1) @(negedge clock);
        while (busy === 1'b1 && len < 400) begin
            len++;
            @(negedge clock);
        end
        i_host.acquire();
    endtask
    // watchdog well beyond the shutdown wait plus all conversions
    initial begin
        repeat (30000) @(negedge clock);
        failures++;
        final_report();
    end
    initial begin
        rst_n = 1'b0;
        strobes_tied = 1'b0;
        channel_sample = 64'h4444_3333_2222_1111;
        repeat (5) @(negedge clock);
        `CHK("oe_rst", 3'b000, {busy, parallel_data_bus_oe, first_channel_flag_oe})
        rst_n = 1'b1;
        i_host.exit_shutdown();
        // latch each code, then time the conversion that uses it
        foreach (rows[i]) begin
            i_host.set_ratio(rows[i].code);
            run_conv(0, n);
            run_conv(1, n);
            `CHK("busy_len", rows[i].cycles, n)
        end
        // leading start alone must not begin a conversion
        i_host.drive_start(1'b1, 1'b0);
        repeat (4) @(negedge clock);
        `CHK("busy_lead", 1'b0, busy)
        i_host.drive_start(1'b1, 1'b1);
        repeat (2) @(negedge clock);
        `CHK("busy_trail", 1'b1, busy)
        i_host.drive_start(1'b0, 1'b0);
        repeat (4) @(negedge clock);
        // separate strobes: four words, flag only on the first
        i_host.set_cs(1'b0);
        `CHK("sel_drive", 2'b10, {first_channel_flag_oe, first_channel_flag})
        `CHK("bus_oe", 1'b1, parallel_data_bus_oe)
        for (int k = 0; k < 4; k++) begin
            i_host.read_pulse();
            `CHK("word", channel_sample[16*k +: 16], parallel_data_bus)
            `CHK("flag", (k == 0), first_channel_flag)
        end
        i_host.set_cs(1'b1);
        `CHK("release", 2'b00, {parallel_data_bus_oe, first_channel_flag_oe})
        // tied strobes: pointer has wrapped back to channel 0
        strobes_tied = 1'b1;
        for (int k = 0; k < 4; k++) begin
            i_host.set_cs(1'b0);
            `CHK("tied_drv", 2'b11, {parallel_data_bus_oe, first_channel_flag_oe})
            `CHK("tied_word", channel_sample[16*k +: 16], parallel_data_bus)
            `CHK("tied_flag", (k == 0), first_channel_flag)
            i_host.set_cs(1'b1);
            `CHK("tied_off", 2'b00, {parallel_data_bus_oe, first_channel_flag_oe})
        end
        // power-on reset mid-conversion drops busy at once, run resumes after release
        strobes_tied = 1'b0;
        i_host.convert(0);
        rst_n = 1'b0;
        @(negedge clock);
        `CHK("rst_mid", 3'b000, {busy, parallel_data_bus_oe, first_channel_flag_oe})
        rst_n = 1'b1;
        // device reset mid-conversion aborts busy and clears the ratio
        i_host.set_ratio(3'h6);
        run_conv(0, n);
        i_host.convert(0);
        repeat (5) @(negedge clock);
        i_host.reset_pulse();
        `CHK("busy_abort", 1'b0, busy)
        // starts in standby are dropped
        i_host.sleep();
        i_host.convert(0);
        repeat (3) @(negedge clock);
        `CHK("busy_low_power_request_n", 1'b0, busy)
        i_host.wake();
        channel_sample = 64'h8888_7777_6666_5555;
        run_conv(0, n);
        `CHK("busy_clr", 2, n)
        // fresh sample set: the first read after it shows its channel 0
        i_host.set_cs(1'b0);
        i_host.read_pulse();
        `CHK("new_word", channel_sample[15:0], parallel_data_bus)
        `CHK("new_flag", 1'b1, first_channel_flag)
        i_host.set_cs(1'b1);
        final_report();
    end
endmodule
`default_nettype wire
